// >>> ast_pkg.sv
package ast_pkg;
   // Register byte addresses
   localparam logic [7:0] CTRL_ONE_ADDR   = 8'h00;
   localparam logic [7:0] CTRL_TWO_ADDR   = 8'h04;
   localparam logic [7:0] CTRL_THREE_ADDR = 8'h08;
   localparam logic [7:0] STATUS_ONE_ADDR = 8'h0C;
   localparam logic [7:0] STATUS_TWO_ADDR = 8'h10;
   localparam logic [7:0] DATA_ADDR       = 8'h14;
   localparam logic [7:0] BAUD_ADDR       = 8'h18;
   localparam logic [7:0] CONFIG_ADDR     = 8'h1C;
   // control_reg_one fields
   localparam int MODULE_ENABLE_BIT = 0;
   localparam int CHAR_NINE_BIT     = 1;
   localparam int TX_INVERT_BIT     = 2;
   // control_reg_two fields
   localparam int TX_ENABLE_BIT     = 0;
   localparam int RX_ENABLE_BIT     = 1;
   localparam int SEND_BREAK_BIT    = 2;
   localparam int TX_IRQ_EN_BIT     = 3;
   localparam int RX_IRQ_EN_BIT     = 4;
   // control_reg_three fields
   localparam int TX_BIT_EIGHT_BIT  = 0;
   localparam int RX_BIT_EIGHT_BIT  = 1;
   // status_reg_one fields
   localparam int TX_EMPTY_BIT      = 0;
   localparam int RX_FULL_BIT       = 1;
   localparam int OVERRUN_BIT       = 2;
   localparam int NOISE_BIT         = 3;
   localparam int FRAMING_BIT       = 4;
   localparam int PARITY_BIT        = 5;
   // status_reg_two fields
   localparam int BREAK_FLAG_BIT    = 0;
   localparam int RX_BUSY_BIT       = 1;
   // baud_rate_reg and configuration fields
   localparam int EXT_BREAK_BIT     = 8;
   localparam int CLK_SRC_BIT       = 0;
   // Reset values and timing counts
   localparam logic [7:0] BAUD_DIV_RESET  = 8'h1A;
   localparam logic [1:0] ALT_SRC_DIV_MAX = 2'h3;
   localparam logic [3:0] FRAME_LEN_8     = 4'hA;
   localparam logic [3:0] FRAME_LEN_9     = 4'hB;
   localparam logic [3:0] RT_LAST         = 4'hF;
   localparam logic [3:0] RT_START_VOTE   = 4'h7;
   localparam logic [3:0] RT_BIT_VOTE     = 4'hA;
   localparam logic [31:0] READ_ZERO      = 32'h0000_0000;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } ast_wb_req_type;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } ast_wb_rsp_type;
endpackage

// >>> ast_serial_transceiver.sv
// Contract
// - 8 or 9 data bits, ninth from tx_bit_eight
// - Preamble of ones precedes first data load
// - Frame: zero start bit, one stop bit
// - Empty flag sets on buffer transfer; irq
// - Idle line rests high unless inverted
// - Module disable releases both pins
// - Repeated all-zero break characters while sending break
// - Finish break, then at least one one
// - Normal break: 10 or 11 zeros
// - Extended break: 11 or 12 zeros
// - Break sets flags, clears data and bit eight
// - Idle character all ones, preamble each transmission
// - Transmitter disable completes current character first
// - Disable-enable during transmission queues idle character
// - Inversion flips every transmitted level
// - rx_bit_eight: ninth bit or copy of bit seven
// - Completed character loads data, sets full, irq
// - Data register: write feeds tx, read shows rx
// - Independent halves share one baud generator
// - Configuration bit picks baud clock source
// - Receiver samples at sixteen times baud
// - Missing stop bit sets framing error with full
//
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module ast_serial_transceiver (
   // Clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   // Register bus
   input  wire ast_pkg::ast_wb_req_type wbReq,
   output ast_pkg::ast_wb_rsp_type      wbRsp,
   // Serial pins
   input  wire logic                    rxdPin,
   output logic                         txdOut,
   output logic                         txdOe,
   output logic                         rxPinOwned,
   // Interrupt requests
   output logic                         txIrq,
   output logic                         rxIrq
);
   typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} ast_tx_state_type;
   typedef enum logic [3:0] {
      RX_IDLE  = 4'b0001,
      RX_START = 4'b0010,
      RX_BITS  = 4'b0100,
      RX_EXTRA = 4'b1000
   } ast_rx_state_type;

   logic [2:0]       ctrlOne_reg;
   logic [4:0]       ctrlTwo_reg;
   logic             txBit8_reg;
   logic [8:0]       baud_reg;
   logic             clkSrc_reg;
   logic             ackReg;
   logic [31:0]      rdData_reg;
   logic             access;
   logic             wrCommit;
   logic             rdCommit;
   logic [7:0]       addr;
   logic [1:0]       altDiv_reg;
   logic [7:0]       rtDiv_reg;
   logic             srcTick;
   logic             rtTick;
   logic             modEn;
   logic             charNine;
   logic             txEn;
   logic             txInvert;
   logic             sendBreak;
   logic             extBreak;
   logic [3:0]       frameLen;
   ast_tx_state_type txState_reg;
   logic [11:0]      txShift_reg;
   logic [3:0]       txBitsLeft_reg;
   logic             txIsBreak_reg;
   logic [3:0]       txRtCnt_reg;
   logic             teDelay_reg;
   logic             pendingIdle_reg;
   logic             txEmpty_reg;
   logic [7:0]       txData_reg;
   logic             txArm_reg;
   logic             txLine_reg;
   logic             txOe_reg;
   logic             bitTick;
   logic             shiftEnd;
   logic             canPick;
   logic             pickIdle;
   logic             pickBreak;
   logic             pickOne;
   logic             pickData;
   logic             teRise;
   logic [2:0]       rxSync_reg;
   logic             rxLevel_reg;
   ast_rx_state_type rxState_reg;
   logic [2:0]       rxHist_reg;
   logic [3:0]       rxRt_reg;
   logic [3:0]       rtNow;
   logic [1:0]       rxVotes_reg;
   logic [2:0]       samp;
   logic             bitVal;
   logic             bitNoisy;
   logic [3:0]       rxIdx_reg;
   logic [8:0]       rxShift_reg;
   logic             rxAllZero_reg;
   logic             rxNoiseAcc_reg;
   logic             rxEn;
   logic             rxEval;
   logic             rxDone;
   logic             rxBreak;
   logic             rxStopBad;
   logic [7:0]       rxData_reg;
   logic             rxBit8_reg;
   logic             rxFull_reg;
   logic             overrun_reg;
   logic             noise_reg;
   logic             framing_reg;
   logic             breakFlag_reg;
   logic             rxArm_reg;

   assign modEn     = ctrlOne_reg[ast_pkg::MODULE_ENABLE_BIT];
   assign charNine  = ctrlOne_reg[ast_pkg::CHAR_NINE_BIT];
   assign txInvert  = ctrlOne_reg[ast_pkg::TX_INVERT_BIT];
   assign txEn      = modEn & ctrlTwo_reg[ast_pkg::TX_ENABLE_BIT];
   assign rxEn      = modEn & ctrlTwo_reg[ast_pkg::RX_ENABLE_BIT];
   assign sendBreak = ctrlTwo_reg[ast_pkg::SEND_BREAK_BIT];
   assign extBreak  = baud_reg[ast_pkg::EXT_BREAK_BIT];
   assign frameLen  = charNine ? ast_pkg::FRAME_LEN_9 : ast_pkg::FRAME_LEN_8;

   // Wishbone classic slave; ack one cycle after strobe, side effects at the ack edge
   assign access   = wbReq.cyc & wbReq.stb;
   assign addr     = {wbReq.adr[7:2], 2'b00};
   assign wrCommit = access & ackReg & wbReq.we;
   assign rdCommit = access & ackReg & ~wbReq.we;
   assign wbRsp    = '{ack: ackReg, dat: rdData_reg};

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ackReg <= 1'b0;
      end else begin
         ackReg <= access & ~ackReg;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdData_reg <= ast_pkg::READ_ZERO;
      end else if (access & ~ackReg) begin
         rdData_reg <= ast_pkg::READ_ZERO;
         unique case (addr)
            ast_pkg::CTRL_ONE_ADDR:   rdData_reg[2:0] <= ctrlOne_reg;
            ast_pkg::CTRL_TWO_ADDR:   rdData_reg[4:0] <= ctrlTwo_reg;
            ast_pkg::CTRL_THREE_ADDR: rdData_reg[1:0] <= {rxBit8_reg, txBit8_reg};
            ast_pkg::STATUS_ONE_ADDR: rdData_reg[5:0] <= {1'b0, framing_reg, noise_reg,
                                                          overrun_reg, rxFull_reg, txEmpty_reg};
            ast_pkg::STATUS_TWO_ADDR: rdData_reg[1:0] <= {rxState_reg != RX_IDLE,
                                                          breakFlag_reg};
            ast_pkg::DATA_ADDR:       rdData_reg[7:0] <= rxData_reg;
            ast_pkg::BAUD_ADDR:       rdData_reg[8:0] <= baud_reg;
            ast_pkg::CONFIG_ADDR:     rdData_reg[0]   <= clkSrc_reg;
            default:                  rdData_reg      <= ast_pkg::READ_ZERO;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrlOne_reg <= 3'h0;
         ctrlTwo_reg <= 5'h00;
         txBit8_reg  <= 1'b0;
         baud_reg    <= {1'b0, ast_pkg::BAUD_DIV_RESET};
         clkSrc_reg  <= 1'b0;
      end else if (wrCommit & wbReq.sel[0]) begin
         unique case (addr)
            ast_pkg::CTRL_ONE_ADDR:   ctrlOne_reg <= wbReq.dat[2:0];
            ast_pkg::CTRL_TWO_ADDR:   ctrlTwo_reg <= wbReq.dat[4:0];
            ast_pkg::CTRL_THREE_ADDR: txBit8_reg  <= wbReq.dat[ast_pkg::TX_BIT_EIGHT_BIT];
            ast_pkg::BAUD_ADDR:       baud_reg    <= {wbReq.sel[1] ? wbReq.dat[8] : baud_reg[8],
                                                      wbReq.dat[7:0]};
            ast_pkg::CONFIG_ADDR:     clkSrc_reg  <= wbReq.dat[ast_pkg::CLK_SRC_BIT];
            default:                  clkSrc_reg  <= clkSrc_reg;
         endcase
      end
   end

   // Baud generator: one 16x tick shared by both halves
   assign srcTick = clkSrc_reg ? (altDiv_reg == ast_pkg::ALT_SRC_DIV_MAX) : 1'b1;
   assign rtTick  = srcTick & (rtDiv_reg == baud_reg[7:0]);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         altDiv_reg <= 2'h0;
         rtDiv_reg  <= 8'h00;
      end else begin
         altDiv_reg <= altDiv_reg + 2'h1;
         if (rtTick) begin
            rtDiv_reg <= 8'h00;
         end else if (srcTick) begin
            rtDiv_reg <= rtDiv_reg + 8'h01;
         end
      end
   end

   // Transmitter next-character choice; idle, break, trailing one, data in that order
   assign bitTick  = rtTick & (txRtCnt_reg == ast_pkg::RT_LAST);
   assign shiftEnd = (txState_reg == TX_SHIFT) & bitTick & (txBitsLeft_reg == 4'h1);
   // Only a trailing one can start on the enable edge itself, so the preamble always precedes data and break
   assign canPick  = ((txState_reg == TX_IDLE) | shiftEnd) & ~teRise;
   assign teRise   = txEn & ~teDelay_reg;
   assign pickIdle  = canPick & txEn & pendingIdle_reg;
   assign pickBreak = canPick & txEn & sendBreak & ~pickIdle;
   assign pickOne   = shiftEnd & txIsBreak_reg & ~pickIdle & ~pickBreak;
   assign pickData  = canPick & txEn & ~txEmpty_reg & ~pickIdle & ~pickBreak & ~pickOne;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         teDelay_reg     <= 1'b0;
         pendingIdle_reg <= 1'b0;
      end else begin
         teDelay_reg <= txEn;
         // A fresh enable always wins over the consuming pick
         if (teRise) begin
            pendingIdle_reg <= 1'b1;
         end else if (pickIdle) begin
            pendingIdle_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         txState_reg    <= TX_IDLE;
         txShift_reg    <= 12'hFFF;
         txBitsLeft_reg <= 4'h0;
         txIsBreak_reg  <= 1'b0;
         txRtCnt_reg    <= 4'h0;
      end else begin
         txRtCnt_reg <= (pickIdle | pickBreak | pickOne | pickData) ? 4'h0
                        : (rtTick ? txRtCnt_reg + 4'h1 : txRtCnt_reg);
         if (pickIdle) begin
            txState_reg    <= TX_SHIFT;
            txShift_reg    <= 12'hFFF;
            txBitsLeft_reg <= frameLen;
            txIsBreak_reg  <= 1'b0;
         end else if (pickBreak) begin
            txState_reg    <= TX_SHIFT;
            txShift_reg    <= 12'h000;
            txBitsLeft_reg <= frameLen + {3'h0, extBreak};
            txIsBreak_reg  <= 1'b1;
         end else if (pickOne) begin
            txShift_reg    <= 12'hFFF;
            txBitsLeft_reg <= 4'h1;
            txIsBreak_reg  <= 1'b0;
         end else if (pickData) begin
            txState_reg    <= TX_SHIFT;
            txShift_reg    <= charNine ? {2'b11, txBit8_reg, txData_reg, 1'b0}
                                       : {3'b111, txData_reg, 1'b0};
            txBitsLeft_reg <= frameLen;
            txIsBreak_reg  <= 1'b0;
         end else if (shiftEnd) begin
            txState_reg <= TX_IDLE;
         end else if ((txState_reg == TX_SHIFT) & bitTick) begin
            txShift_reg    <= {~txIsBreak_reg, txShift_reg[11:1]};
            txBitsLeft_reg <= txBitsLeft_reg - 4'h1;
         end
      end
   end

   // Empty flag clears only after a status read followed by a data write
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         txEmpty_reg <= 1'b1;
         txArm_reg   <= 1'b0;
         txData_reg  <= 8'h00;
      end else begin
         if (wrCommit & wbReq.sel[0] & (addr == ast_pkg::DATA_ADDR)) begin
            txData_reg <= wbReq.dat[7:0];
         end
         if (pickData) begin
            txEmpty_reg <= 1'b1;
         end else if (wrCommit & (addr == ast_pkg::DATA_ADDR) & txArm_reg) begin
            txEmpty_reg <= 1'b0;
         end
         if (rdCommit & (addr == ast_pkg::STATUS_ONE_ADDR) & txEmpty_reg) begin
            txArm_reg <= 1'b1;
         end else if (wrCommit & (addr == ast_pkg::DATA_ADDR)) begin
            txArm_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         txLine_reg <= 1'b1;
         txOe_reg   <= 1'b0;
      end else begin
         txLine_reg <= ((txState_reg == TX_SHIFT) ? txShift_reg[0] : 1'b1) ^ txInvert;
         txOe_reg   <= modEn;
      end
   end

   assign txdOut     = txLine_reg;
   assign txdOe      = txOe_reg;
   assign rxPinOwned = rxEn;
   assign txIrq      = txEmpty_reg & ctrlTwo_reg[ast_pkg::TX_IRQ_EN_BIT];
   assign rxIrq      = rxFull_reg & ctrlTwo_reg[ast_pkg::RX_IRQ_EN_BIT];

   // Receiver: pin resynchronised over three flops, change taken when last two agree
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rxSync_reg  <= 3'b111;
         rxLevel_reg <= 1'b1;
      end else begin
         rxSync_reg <= {rxSync_reg[1:0], rxdPin};
         if (rxSync_reg[1] == rxSync_reg[2]) begin
            rxLevel_reg <= rxSync_reg[2];
         end
      end
   end

   assign rtNow    = rxRt_reg + 4'h1;
   assign samp     = {rxVotes_reg, rxLevel_reg};
   assign bitVal   = (samp[0] & samp[1]) | (samp[0] & samp[2]) | (samp[1] & samp[2]);
   assign bitNoisy = (samp != 3'b000) & (samp != 3'b111);
   assign rxEval   = rtTick & (rtNow == ast_pkg::RT_BIT_VOTE);
   // Break needs the extra zero when extended break is selected
   assign rxBreak   = rxEval & ~bitVal & (((rxState_reg == RX_BITS) & rxAllZero_reg &
                      (rxIdx_reg == frameLen - 4'h2) & ~extBreak) |
                      (rxState_reg == RX_EXTRA));
   assign rxDone    = rxEval & ((rxState_reg == RX_EXTRA) | ((rxState_reg == RX_BITS) &
                      (rxIdx_reg == frameLen - 4'h2) & ~(~bitVal & rxAllZero_reg & extBreak)));
   assign rxStopBad = ~bitVal | (rxState_reg == RX_EXTRA);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rxState_reg    <= RX_IDLE;
         rxHist_reg     <= 3'b000;
         rxRt_reg       <= 4'h0;
         rxVotes_reg    <= 2'b00;
         rxIdx_reg      <= 4'h0;
         rxShift_reg    <= 9'h000;
         rxAllZero_reg  <= 1'b1;
         rxNoiseAcc_reg <= 1'b0;
      end else if (~rxEn) begin
         rxState_reg <= RX_IDLE;
         rxHist_reg  <= 3'b000;
      end else if (rtTick) begin
         rxRt_reg <= rtNow;
         if ((rtNow == 4'h3) | (rtNow == 4'h5) | (rtNow == 4'h7) | (rtNow == 4'h8) |
             (rtNow == 4'h9)) begin
            rxVotes_reg <= {rxVotes_reg[0], rxLevel_reg};
         end
         unique case (rxState_reg)
            RX_IDLE: begin
               rxHist_reg <= {rxHist_reg[1:0], rxLevel_reg};
               if ((rxHist_reg == 3'b111) & ~rxLevel_reg) begin
                  rxState_reg    <= RX_START;
                  rxRt_reg       <= 4'h1;
                  rxIdx_reg      <= 4'h0;
                  rxAllZero_reg  <= 1'b1;
                  rxNoiseAcc_reg <= 1'b0;
               end
            end
            RX_START: begin
               if ((rtNow == ast_pkg::RT_START_VOTE) & bitVal) begin
                  rxState_reg <= RX_IDLE;
                  rxHist_reg  <= 3'b000;
               end else if (rtNow == ast_pkg::RT_START_VOTE) begin
                  rxNoiseAcc_reg <= bitNoisy;
               end else if (rtNow == 4'h0) begin
                  rxState_reg <= RX_BITS;
               end
            end
            RX_BITS: begin
               if (rxEval) begin
                  rxNoiseAcc_reg <= rxNoiseAcc_reg | bitNoisy;
                  if (rxIdx_reg == frameLen - 4'h2) begin
                     rxState_reg <= rxDone ? RX_IDLE : RX_EXTRA;
                     rxHist_reg  <= 3'b000;
                  end else begin
                     rxShift_reg   <= {bitVal, rxShift_reg[8:1]};
                     rxAllZero_reg <= rxAllZero_reg & ~bitVal;
                     rxIdx_reg     <= rxIdx_reg + 4'h1;
                  end
               end
            end
            RX_EXTRA: begin
               if (rxEval) begin
                  rxState_reg <= RX_IDLE;
               end
            end
         endcase
      end
   end

   // Flag set always wins over the software clear sequence
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rxData_reg    <= 8'h00;
         rxBit8_reg    <= 1'b0;
         rxFull_reg    <= 1'b0;
         overrun_reg   <= 1'b0;
         noise_reg     <= 1'b0;
         framing_reg   <= 1'b0;
         breakFlag_reg <= 1'b0;
         rxArm_reg     <= 1'b0;
      end else begin
         if (rxDone) begin
            rxFull_reg  <= 1'b1;
            framing_reg <= rxStopBad;
            noise_reg   <= rxNoiseAcc_reg | bitNoisy;
            overrun_reg <= rxFull_reg;
            if (rxBreak) begin
               rxData_reg <= 8'h00;
               rxBit8_reg <= 1'b0;
            end else if (~rxFull_reg) begin
               rxData_reg <= charNine ? rxShift_reg[7:0] : rxShift_reg[8:1];
               rxBit8_reg <= rxShift_reg[8];
            end
         end else if (rdCommit & (addr == ast_pkg::DATA_ADDR) & rxArm_reg) begin
            rxFull_reg  <= 1'b0;
            framing_reg <= 1'b0;
            noise_reg   <= 1'b0;
            overrun_reg <= 1'b0;
         end
         if (rxBreak) begin
            breakFlag_reg <= 1'b1;
         end else if (wrCommit & wbReq.sel[0] & (addr == ast_pkg::STATUS_TWO_ADDR) &
                      wbReq.dat[ast_pkg::BREAK_FLAG_BIT]) begin
            breakFlag_reg <= 1'b0;
         end
         if (rdCommit & (addr == ast_pkg::STATUS_ONE_ADDR) & rxFull_reg) begin
            rxArm_reg <= 1'b1;
         end else if (rdCommit & (addr == ast_pkg::DATA_ADDR)) begin
            rxArm_reg <= 1'b0;
         end
      end
   end

   // Checks
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence dataLoad_s;
      pickData ##1 (txState_reg == TX_SHIFT);
   endsequence

   tx_frame_a: assert property (dataLoad_s |-> txShift_reg[0] == 1'b0 &&
      txShift_reg[frameLen - 4'h1] == 1'b1 && txBitsLeft_reg == frameLen)
      else $error("data frame lacks start or stop bit");
   empty_set_a: assert property (pickData |=> txEmpty_reg && txIrq ==
      ctrlTwo_reg[ast_pkg::TX_IRQ_EN_BIT]) else $error("empty flag not set on transfer");
   idle_line_a: assert property ((txState_reg == TX_IDLE) |=>
      txLine_reg == !$past(txInvert)) else $error("idle line level wrong");
   pin_release_a: assert property (!modEn ##1 !modEn |-> !txdOe && !rxPinOwned)
      else $error("pins held while module disabled");
   break_len_a: assert property (pickBreak |=> txShift_reg == 12'h000 &&
      txBitsLeft_reg == frameLen + {3'h0, extBreak}) else $error("break length wrong");
   break_tail_a: assert property (pickOne |=> txShift_reg[0] &&
      (txState_reg == TX_SHIFT)) else $error("no one after break");
   preamble_first_a: assert property (teRise |-> (!pickData && !pickBreak) ##1
      (pendingIdle_reg && !pickData)) else $error("data before preamble");
   rx_break_a: assert property (rxBreak |=> rxData_reg == 8'h00 && !rxBit8_reg &&
      breakFlag_reg && framing_reg && rxFull_reg) else $error("break flags wrong");
   rx_full_fe_a: assert property (rxDone |=> rxFull_reg &&
      framing_reg == $past(rxStopBad)) else $error("full and framing not together");
   rx_irq_a: assert property (rxFull_reg && ctrlTwo_reg[ast_pkg::RX_IRQ_EN_BIT] |-> rxIrq)
      else $error("receive irq missing");
endmodule

// >>> ast_remote_dev.sv
`timescale 1ns/1ps
module ast_remote_dev (
   // Clock
   input  wire logic sys_clk,
   // Serial line
   input  wire logic txdLine,
   output logic      rxdLine
);
   initial rxdLine = 1'b1;
   // Called at a rising edge; each bit lasts 16 clocks at divisor 0
   task automatic sendBits(input logic [11:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         rxdLine <= bits[i];
         repeat (16) @(posedge sys_clk);
      end
      rxdLine <= 1'b1;
   endtask
   // Samples mid-bit, start bit first
   task automatic getFrame(output logic [9:0] frm);
      while (txdLine !== 1'b0) @(posedge sys_clk);
      repeat (7) @(posedge sys_clk);
      for (int i = 0; i < 10; i++) begin
         frm[i] = txdLine;
         repeat (16) @(posedge sys_clk);
      end
   endtask
endmodule

// >>> async_serial_transceiver_test.sv
`timescale 1ns/1ps
module async_serial_transceiver_test;
   logic                    sys_clk = 1'b0;
   logic                    rst = 1'b1;
   ast_pkg::ast_wb_req_type wbReq = '0;
   ast_pkg::ast_wb_rsp_type wbRsp;
   logic                    rxdPin, txdOut, txdOe, rxPinOwned, txIrq, rxIrq;
   logic [31:0]             rd;
   logic [9:0]              frm;
   int                      err_count = 0;
   int                      comparisons = 0;
   int                      n;
   int                      curLow = 0;
   int                      lastLow = 0;
   always #5 sys_clk = ~sys_clk;
   ast_serial_transceiver dut (.sys_clk(sys_clk), .rst(rst), .wbReq(wbReq), .wbRsp(wbRsp),
      .rxdPin(rxdPin), .txdOut(txdOut), .txdOe(txdOe), .rxPinOwned(rxPinOwned),
      .txIrq(txIrq), .rxIrq(rxIrq));
   ast_remote_dev partner (.sys_clk(sys_clk), .txdLine(txdOut), .rxdLine(rxdPin));
   // Length of the latest low run on the transmit line
   always @(posedge sys_clk) begin
      curLow <= (txdOut === 1'b0) ? curLow + 1 : 0;
      if (txdOut === 1'b1 && curLow != 0) lastLow <= curLow;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd);
      wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wd};
      do begin
         @(posedge sys_clk);
      end while (wbRsp.ack !== 1'b1);
      rd = wbRsp.dat;
      wbReq <= '0;
      @(posedge sys_clk);
   endtask
   task automatic end_of_test();
      $display("err_count=%0d comparisons=%0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #900_000;
      err_count++;
      $display("Error at %0t: watchdog expired", $time);
      end_of_test();
   end
   initial begin
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      chk(txdOut, 1);
      bus(0, ast_pkg::STATUS_ONE_ADDR, 0);
      chk(rd[0], 1);
      bus(0, 8'h20, 0);
      chk(rd, 32'h0000_0000);
      bus(1, ast_pkg::BAUD_ADDR, 0);
      bus(1, ast_pkg::CTRL_ONE_ADDR, 32'h0000_0001);
      bus(1, ast_pkg::CTRL_TWO_ADDR, 32'h0000_001B);
      chk({txdOe, rxPinOwned, txIrq}, 3'b111);
      bus(0, ast_pkg::STATUS_ONE_ADDR, 0);
      bus(1, ast_pkg::DATA_ADDR, 32'h0000_00A5);
      n = 0;
      while (txdOut !== 1'b0 && n < 1000) begin
         @(posedge sys_clk);
         n++;
      end
      chk(n >= 150, 1);
      partner.getFrame(frm);
      chk(frm, {1'b1, 8'hA5, 1'b0});
      chk({txdOut, txIrq}, 2'b11);
      partner.sendBits({2'b11, 8'hC3, 1'b0}, 11);
      chk(rxIrq, 1);
      bus(0, ast_pkg::STATUS_ONE_ADDR, 0);
      chk({rd[4], rd[1]}, 2'b01);
      bus(0, ast_pkg::DATA_ADDR, 0);
      chk(rd[7:0], 8'hC3);
      bus(0, ast_pkg::CTRL_THREE_ADDR, 0);
      chk(rd[1], 1);
      partner.sendBits(12'h000, 11);
      repeat (20) @(posedge sys_clk);
      bus(0, ast_pkg::STATUS_ONE_ADDR, 0);
      chk({rd[4], rd[1]}, 2'b11);
      bus(0, ast_pkg::STATUS_TWO_ADDR, 0);
      chk(rd[0], 1);
      bus(0, ast_pkg::DATA_ADDR, 0);
      chk(rd[7:0], 8'h00);
      bus(0, ast_pkg::CTRL_THREE_ADDR, 0);
      chk(rd[1], 0);
      bus(1, ast_pkg::CTRL_TWO_ADDR, 32'h0000_001F);
      while (txdOut !== 1'b0) @(posedge sys_clk);
      bus(1, ast_pkg::CTRL_TWO_ADDR, 32'h0000_001B);
      repeat (200) @(posedge sys_clk);
      chk(lastLow, 160);
      bus(1, ast_pkg::STATUS_TWO_ADDR, 32'h0000_0001);
      bus(0, ast_pkg::STATUS_TWO_ADDR, 0);
      chk(rd[0], 0);
      bus(1, ast_pkg::CTRL_ONE_ADDR, 32'h0000_0003);
      partner.sendBits({2'b11, 9'h15A, 1'b0}, 12);
      bus(0, ast_pkg::STATUS_ONE_ADDR, 0);
      bus(0, ast_pkg::DATA_ADDR, 0);
      chk(rd[7:0], 8'h5A);
      bus(0, ast_pkg::CTRL_THREE_ADDR, 0);
      chk(rd[1], 1);
      bus(1, ast_pkg::CTRL_ONE_ADDR, 32'h0000_0005);
      bus(1, ast_pkg::BAUD_ADDR, 32'h0000_0100);
      chk(txdOut, 0);
      partner.sendBits(12'h400, 11);
      bus(0, ast_pkg::STATUS_ONE_ADDR, 0);
      chk({rd[4], rd[1]}, 2'b11);
      bus(0, ast_pkg::STATUS_TWO_ADDR, 0);
      chk(rd[0], 0);
      bus(0, ast_pkg::DATA_ADDR, 0);
      partner.sendBits(12'h000, 11);
      bus(0, ast_pkg::STATUS_TWO_ADDR, 0);
      chk(rd[0], 1);
      bus(1, ast_pkg::CONFIG_ADDR, 32'h0000_0001);
      bus(0, ast_pkg::CONFIG_ADDR, 0);
      chk(rd[0], 1);
      bus(1, ast_pkg::CTRL_ONE_ADDR, 0);
      @(posedge sys_clk);
      chk({txdOe, rxPinOwned}, 2'b00);
      end_of_test();
   end
endmodule
